// >>> rtl/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CMD_STAT_OFFSET = 12'h004;

  // ****************************************
  // command field positions
  // ****************************************
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_VGA_BIT = 5;
  localparam int CMD_PARITY_BIT = 6;
  localparam int CMD_SERR_BIT = 8;
  localparam int CMD_FB2B_BIT = 9;
  // only bits 0,1,2,5,6,8,9 accept writes
  localparam logic [15:0] CMD_WRITE_MASK = 16'h0367;
  localparam logic [15:0] CMD_RESET = 16'h0000;

  // ****************************************
  // status field positions (32-bit word)
  // ****************************************
  localparam int STAT_CAP_BIT = 20;
  localparam int STAT_66MHZ_BIT = 21;
  localparam int STAT_FB2B_BIT = 23;
  localparam int STAT_DPERR_BIT = 24;
  localparam int STAT_DEVSEL_LO = 25;
  localparam int STAT_SIG_TABORT_BIT = 27;
  localparam int STAT_RCV_TABORT_BIT = 28;
  localparam int STAT_RCV_MABORT_BIT = 29;
  localparam int STAT_SIG_SERR_BIT = 30;
  localparam int STAT_PERR_BIT = 31;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  // sticky write-one-to-clear flags: bits 31..27 and 24
  localparam logic [31:0] W1C_MASK = 32'hF900_0000;
  localparam logic [31:0] W1C_RESET = 32'h0000_0000;

  // ****************************************
  // vga palette addresses (low ten bits)
  // ****************************************
  localparam logic [9:0] VGA_PAL_A = 10'h3c6;
  localparam logic [9:0] VGA_PAL_B = 10'h3c8;
  localparam logic [9:0] VGA_PAL_C = 10'h3c9;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic io_req;
    logic io_write;
    logic mem_req;
    logic [15:0] addr;
    logic sec_req;
    logic upstream_req;
  } txn_req_t;

  typedef struct packed {
    logic io_claim;
    logic mem_claim;
    logic palette_claim;
    logic upstream_master_ok;
    logic sec_claim;
    logic fast_b2b_ok;
    logic parity_action;
  } txn_rsp_t;

  typedef struct packed {
    logic parity_error_detected;
    logic signaled_target_abort;
    logic received_target_abort;
    logic received_master_abort;
    logic system_error_request;
  } events_t;

endpackage

// >>> rtl/bridge_primary_command_status.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps

module bridge_primary_command_status
  (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // apb slave
    input wire bridge_cfg_pkg::apb_req_t apb_req_in,
    output bridge_cfg_pkg::apb_rsp_t apb_rsp_out,
    // primary and secondary transaction decode
    input wire bridge_cfg_pkg::txn_req_t txn_req_in,
    output bridge_cfg_pkg::txn_rsp_t txn_rsp_out,
    // events from the forwarding logic
    input wire bridge_cfg_pkg::events_t events_in,
    // primary parity error pin, active low, asynchronous
    input wire logic primary_parity_error_pin_n_in,
    // primary system error pin, open drain, active low
    output logic primary_system_error_out,
    output logic primary_system_error_oe_out
  );
  import bridge_cfg_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] cmd;
    logic [31:0] w1c;
    logic [2:0] perr_sync;
    logic perr_level_n;
    apb_rsp_t rsp;
    txn_rsp_t txn;
    logic serr_oe;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic setup_phase;
  logic access_done;
  logic addr_hit;
  logic vga_hit;
  logic perr_asserted;
  logic [31:0] read_word;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [15:0] status_hi;

  // ****************************************
  // read view of the register word
  // ****************************************
  // fixed capability bits ride on top of the sticky flags; reserved stay 0
  always_comb
  begin
    status_hi = state_q.w1c[31:16];
    status_hi[STAT_CAP_BIT-16] = 1'b1;
    status_hi[STAT_66MHZ_BIT-16] = 1'b1;
    status_hi[STAT_FB2B_BIT-16] = 1'b1;
    status_hi[STAT_DEVSEL_LO-16 +: 2] = DEVSEL_MEDIUM;
    // command bits 3, 4, 7, 15:10 never store, so they read 0
    read_word = {status_hi, state_q.cmd & CMD_WRITE_MASK};
  end

  // ****************************************
  // decode helpers
  // ****************************************
  assign setup_phase = apb_req_in.psel & ~apb_req_in.penable;
  assign access_done = apb_req_in.psel & apb_req_in.penable
    & state_q.rsp.pready;
  assign addr_hit = (apb_req_in.paddr[ADDR_W-1:2]
    == CMD_STAT_OFFSET[ADDR_W-1:2]);
  // bits 15:10 are not decoded, so isa aliases match too
  assign vga_hit = (txn_req_in.addr[9:0] == VGA_PAL_A)
    | (txn_req_in.addr[9:0] == VGA_PAL_B)
    | (txn_req_in.addr[9:0] == VGA_PAL_C);
  // pin counts as asserted only once two sync stages agree on low
  assign perr_asserted = ~state_q.perr_level_n;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    set_vec = 32'h0000_0000;
    clr_vec = 32'h0000_0000;

    // pin synchroniser: stage 0 only feeds stage 1
    state_d.perr_sync = {state_q.perr_sync[1:0],
      primary_parity_error_pin_n_in};
    if (state_q.perr_sync[1] == state_q.perr_sync[2])
    begin
      state_d.perr_level_n = state_q.perr_sync[2];
    end

    // apb: answer in the first access cycle, no wait states
    state_d.rsp.pready = setup_phase;
    state_d.rsp.pslverr = setup_phase & ~addr_hit;
    state_d.rsp.prdata = 32'h0000_0000;
    if (setup_phase && addr_hit && !apb_req_in.pwrite)
    begin
      state_d.rsp.prdata = read_word;
    end

    // writes take effect only at the completing edge
    if (access_done && addr_hit && apb_req_in.pwrite)
    begin
      state_d.cmd = (state_q.cmd & ~CMD_WRITE_MASK)
        | (apb_req_in.pwdata[15:0] & CMD_WRITE_MASK);
      clr_vec = apb_req_in.pwdata & W1C_MASK;
    end

    // sticky events
    set_vec[STAT_DPERR_BIT] = perr_asserted
      & state_q.cmd[CMD_PARITY_BIT];
    set_vec[STAT_SIG_TABORT_BIT] =
      events_in.signaled_target_abort;
    set_vec[STAT_RCV_TABORT_BIT] =
      events_in.received_target_abort;
    set_vec[STAT_RCV_MABORT_BIT] =
      events_in.received_master_abort;
    set_vec[STAT_SIG_SERR_BIT] = state_q.serr_oe;
    set_vec[STAT_PERR_BIT] = events_in.parity_error_detected;
    // a set in the clearing cycle wins, so no event is lost
    state_d.w1c = ((state_q.w1c & ~clr_vec) | set_vec)
      & W1C_MASK;

    // primary and secondary decode gating
    state_d.txn.palette_claim = state_q.cmd[CMD_VGA_BIT]
      & txn_req_in.io_req & txn_req_in.io_write & vga_hit;
    state_d.txn.io_claim = txn_req_in.io_req
      & state_q.cmd[CMD_IO_BIT];
    state_d.txn.mem_claim = txn_req_in.mem_req
      & state_q.cmd[CMD_MEM_BIT];
    state_d.txn.upstream_master_ok = txn_req_in.upstream_req
      & state_q.cmd[CMD_MASTER_BIT];
    state_d.txn.sec_claim = txn_req_in.sec_req
      & state_q.cmd[CMD_MASTER_BIT];
    state_d.txn.fast_b2b_ok = state_q.cmd[CMD_FB2B_BIT];
    // parity actions only when enabled; otherwise carry on silently
    state_d.txn.parity_action = state_q.cmd[CMD_PARITY_BIT]
      & (events_in.parity_error_detected | perr_asserted);

    // system error driver held off while its enable is clear
    state_d.serr_oe = events_in.system_error_request
      & state_q.cmd[CMD_SERR_BIT];

    if (reset_in)
    begin
      state_d = '0;
      state_d.cmd = CMD_RESET;
      state_d.w1c = W1C_RESET;
      state_d.perr_sync = 3'h7;
      state_d.perr_level_n = 1'b1;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk_in)
  begin
    state_q <= state_d;
  end

  // outputs come straight from state flops, except the system error data, tied low
  assign apb_rsp_out = state_q.rsp;
  assign txn_rsp_out = state_q.txn;
  assign primary_system_error_out = 1'b0;
  assign primary_system_error_oe_out = state_q.serr_oe;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_cmd_write(int bitn);
    access_done && addr_hit && apb_req_in.pwrite
      && apb_req_in.pwdata[bitn];
  endsequence

  // a write that leaves the given status bit at zero
  sequence s_cmd_write_zero(int bitn);
    access_done && addr_hit && apb_req_in.pwrite
      && !apb_req_in.pwdata[bitn];
  endsequence

  a_io_claim_gate:
    assert property (txn_req_in.io_req && !state_q.cmd[CMD_IO_BIT]
      |=> !txn_rsp_out.io_claim)
    else $error("io claimed while io decode off");

  a_mem_claim_gate:
    assert property (txn_rsp_out.mem_claim
      |-> $past(state_q.cmd[CMD_MEM_BIT]) && $past(txn_req_in.mem_req))
    else $error("memory claim without enable");

  a_master_gate:
    assert property (txn_rsp_out.upstream_master_ok
      || txn_rsp_out.sec_claim |-> $past(state_q.cmd[CMD_MASTER_BIT]))
    else $error("mastering while bus master off");

  a_ro_cmd_zero:
    assert property (apb_rsp_out.prdata[15:10] == 6'h00
      && apb_rsp_out.prdata[7] == 1'b0 && apb_rsp_out.prdata[4:3] == 2'h0)
    else $error("read-only command bits not zero");

  a_palette_hit:
    assert property (state_q.cmd[CMD_VGA_BIT] && txn_req_in.io_req
      && txn_req_in.io_write && txn_req_in.addr[9:0] == 10'h3c8
      |=> txn_rsp_out.palette_claim)
    else $error("palette write not claimed");

  a_serr_gate:
    assert property (primary_system_error_oe_out
      |-> $past(state_q.cmd[CMD_SERR_BIT]))
    else $error("system error driven while disabled");

  a_serr_flag:
    assert property (primary_system_error_oe_out
      |=> state_q.w1c[STAT_SIG_SERR_BIT])
    else $error("system error flag not set");

  a_dperr_flag:
    assert property (perr_asserted && state_q.cmd[CMD_PARITY_BIT]
      |=> state_q.w1c[STAT_DPERR_BIT])
    else $error("data parity flag missed");

  a_fixed_status:
    assert property (setup_phase && addr_hit && !apb_req_in.pwrite
      |=> apb_rsp_out.prdata[26:25] == DEVSEL_MEDIUM
      && apb_rsp_out.prdata[23:20] == 4'hb
      && apb_rsp_out.prdata[19:16] == 4'h0)
    else $error("fixed status bits wrong");

  a_w1c_clear:
    assert property (s_cmd_write(STAT_RCV_MABORT_BIT)
      ##0 !events_in.received_master_abort
      |=> !state_q.w1c[STAT_RCV_MABORT_BIT])
    else $error("write one did not clear flag");

  a_set_wins:
    assert property (events_in.signaled_target_abort
      |=> state_q.w1c[STAT_SIG_TABORT_BIT])
    else $error("target abort event lost");

  a_apb_answer:
    assert property (setup_phase ##1 apb_req_in.psel
      |-> apb_rsp_out.pready ##1 !apb_rsp_out.pready)
    else $error("apb answer not single cycle");

  // ****************************************
  // assertions: read-only and reserved bits
  // ****************************************
  // the first five watch stored state, so a bad write mask shows at once; the last three watch read data
  a_special_zero:
    assert property (!state_q.cmd[3])
    else $error("special cycle enable stored");

  a_inval_zero:
    assert property (!state_q.cmd[4])
    else $error("write and invalidate enable stored");

  a_stepping_zero:
    assert property (!state_q.cmd[7])
    else $error("stepping enable stored");

  a_cmd_rsvd_zero:
    assert property (state_q.cmd[15:10] == 6'h00)
    else $error("reserved command bits stored");

  a_stat_rsvd_zero:
    assert property ((state_q.w1c & ~W1C_MASK) == 32'h0000_0000)
    else $error("reserved status bits stored");

  a_cap_list:
    assert property (setup_phase && addr_hit && !apb_req_in.pwrite
      |=> apb_rsp_out.prdata[STAT_CAP_BIT])
    else $error("capability list bit low");

  a_speed_66:
    assert property (setup_phase && addr_hit && !apb_req_in.pwrite
      |=> apb_rsp_out.prdata[STAT_66MHZ_BIT])
    else $error("66 MHz capable bit low");

  a_fb2b_capable:
    assert property (setup_phase && addr_hit && !apb_req_in.pwrite
      |=> apb_rsp_out.prdata[STAT_FB2B_BIT])
    else $error("fast back-to-back capable bit low");

  // ****************************************
  // assertions: events and decode
  // ****************************************
  a_rtabort_flag:
    assert property (events_in.received_target_abort
      |=> state_q.w1c[STAT_RCV_TABORT_BIT])
    else $error("received target abort flag missed");

  a_mabort_flag:
    assert property (events_in.received_master_abort
      |=> state_q.w1c[STAT_RCV_MABORT_BIT])
    else $error("received master abort flag missed");

  a_perr_flag:
    assert property (events_in.parity_error_detected
      |=> state_q.w1c[STAT_PERR_BIT])
    else $error("detected parity flag missed");

  a_dperr_gated:
    assert property ($rose(state_q.w1c[STAT_DPERR_BIT])
      |-> $past(perr_asserted) && $past(state_q.cmd[CMD_PARITY_BIT]))
    else $error("data parity flag set while response off");

  // the clear and the event in one cycle must leave the flag set
  a_event_beats_clear:
    assert property (s_cmd_write(STAT_SIG_TABORT_BIT)
      ##0 events_in.signaled_target_abort
      |=> state_q.w1c[STAT_SIG_TABORT_BIT])
    else $error("clear beat a same-cycle event");

  a_w1c_zero_keeps:
    assert property (s_cmd_write_zero(STAT_PERR_BIT)
      ##0 state_q.w1c[STAT_PERR_BIT]
      |=> state_q.w1c[STAT_PERR_BIT])
    else $error("writing zero cleared a flag");

  a_fb2b_follow:
    assert property (txn_rsp_out.fast_b2b_ok
      == $past(state_q.cmd[CMD_FB2B_BIT]))
    else $error("fast back-to-back permit wrong");

  a_parity_quiet:
    assert property (txn_rsp_out.parity_action
      |-> $past(state_q.cmd[CMD_PARITY_BIT]))
    else $error("parity action while response off");

  a_palette_off:
    assert property (txn_rsp_out.palette_claim
      |-> $past(state_q.cmd[CMD_VGA_BIT]))
    else $error("palette claimed while snoop off");

  a_io_claim_on:
    assert property (txn_req_in.io_req && state_q.cmd[CMD_IO_BIT]
      |=> txn_rsp_out.io_claim)
    else $error("enabled io transaction not claimed");

  // reset must be watched although the others are held off in it
  a_reset_clear:
    assert property (disable iff (1'b0) reset_in
      |=> state_q.cmd == CMD_RESET && state_q.w1c == W1C_RESET
      && !primary_system_error_oe_out && !apb_rsp_out.pready)
    else $error("reset left state behind");

endmodule

// >>> verification/pci_far_side.sv
`timescale 1ns/100ps

// ****
// primary bus masters and pins, as seen from the bridge
// ****
module pci_far_side
  (
    // commands from the bench
    input wire bridge_cfg_pkg::txn_req_t cmd_req_in,
    input wire bridge_cfg_pkg::events_t cmd_ev_in,
    input wire logic cmd_perr_in,
    // toward the bridge
    output bridge_cfg_pkg::txn_req_t txn_req_out,
    output bridge_cfg_pkg::events_t events_out,
    output logic parity_pin_n_out,
    // open-drain system error wire
    input wire logic serr_drv_in,
    input wire logic serr_oe_in,
    output logic serr_wire_out
  );
  import bridge_cfg_pkg::*;

  // traffic and events pass straight on; the pin is active low
  assign txn_req_out = cmd_req_in;
  assign events_out = cmd_ev_in;
  assign parity_pin_n_out = !cmd_perr_in;
  // pull-up holds the wire high unless the bridge pulls it
  assign serr_wire_out = serr_oe_in ? serr_drv_in : 1'b1;
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps

module tb;
  import bridge_cfg_pkg::*;
  localparam logic [31:0] FIXED = 32'h02b0_0000;
  localparam logic [11:0] OFF = CMD_STAT_OFFSET;
  logic sys_clk_in;
  logic reset_in;
  apb_req_t req;
  apb_rsp_t rsp;
  txn_req_t tcmd;
  txn_req_t treq;
  txn_req_t t;
  txn_rsp_t trsp;
  events_t ecmd;
  events_t ev;
  events_t e;
  logic perr_cmd;
  logic pin_n;
  logic serr_o;
  logic serr_oe;
  logic serr_w;
  int n_fail;
  int total_checks;
  logic [15:0] cmd_e;
  logic [15:0] w16;
  logic [31:0] rd;
  logic [31:0] flg;
  logic err;
  int fb [4] = '{31, 27, 28, 29};
  logic [9:0] pals [3] = '{VGA_PAL_A, VGA_PAL_B, VGA_PAL_C};

  // ****
  // design, far side and clock
  // ****
  bridge_primary_command_status i_bridge_primary_command_status (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .apb_req_in(req), .apb_rsp_out(rsp),
    .txn_req_in(treq), .txn_rsp_out(trsp), .events_in(ev),
    .primary_parity_error_pin_n_in(pin_n),
    .primary_system_error_out(serr_o),
    .primary_system_error_oe_out(serr_oe));
  pci_far_side i_pci_far_side (
    .cmd_req_in(tcmd), .cmd_ev_in(ecmd), .cmd_perr_in(perr_cmd),
    .txn_req_out(treq), .events_out(ev), .parity_pin_n_out(pin_n),
    .serr_drv_in(serr_o), .serr_oe_in(serr_oe), .serr_wire_out(serr_w));

  // 50 ns period
  initial
  begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // ****
  // checks and bus cycles
  // ****
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  // request held until pready is seen at a rising edge; data taken there
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
    int n;
    @(posedge sys_clk_in);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge sys_clk_in);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (rsp.pready !== 1'b1);
    chk("pready wait", 32'h1, 32'(n));
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rchk(string nm, logic [31:0] x);
    apb(1'b0, OFF, 32'h0);
    chk(nm, x, rd);
  endtask

  function automatic txn_rsp_t exp_rsp(logic [15:0] c, txn_req_t r,
    events_t v);
    txn_rsp_t x;
    x.io_claim = r.io_req & c[0];
    x.mem_claim = r.mem_req & c[1];
    x.palette_claim = c[5] & r.io_req & r.io_write &
      (r.addr[9:0] inside {VGA_PAL_A, VGA_PAL_B, VGA_PAL_C});
    x.upstream_master_ok = r.upstream_req & c[2];
    x.sec_claim = r.sec_req & c[2];
    x.fast_b2b_ok = c[9];
    x.parity_action = c[6] & v.parity_error_detected;
    return x;
  endfunction

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // guard far above the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    conclude();
  end

  // main sequence
  initial
  begin
    reset_in = 1'b1;
    req = '0;
    tcmd = '0;
    ecmd = '0;
    perr_cmd = 1'b0;
    n_fail = 0;
    total_checks = 0;
    flg = '0;
    void'($urandom(32'h2cd6));
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rchk("reset word", FIXED);
    apb(1'b1, OFF, 32'hffff_ffff);
    cmd_e = CMD_WRITE_MASK;
    rchk("ones kept", FIXED | cmd_e);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // the parity and three abort events each raise their own sticky flag
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk_in);
      ecmd <= events_t'(5'h10 >> i);
      @(posedge sys_clk_in);
      ecmd <= '0;
      flg |= 32'h1 << fb[i];
      rchk("event flag", FIXED | cmd_e | flg);
    end
    apb(1'b1, OFF, {16'h0, cmd_e});
    rchk("zeros keep", FIXED | cmd_e | flg);
    for (int i = 0; i < 4; i++)
    begin
      flg &= ~(32'h1 << fb[i]);
      apb(1'b1, OFF, (32'h1 << fb[i]) | cmd_e);
      rchk("one clears", FIXED | cmd_e | flg);
    end
    // driver only when bit 8 is set; wire pulled up otherwise
    for (int s = 0; s < 2; s++)
    begin
      cmd_e = s ? 16'h0100 : 16'h0000;
      apb(1'b1, OFF, {16'h0, cmd_e});
      @(posedge sys_clk_in);
      ecmd <= 5'h01;
      @(posedge sys_clk_in);
      #1 chk("serr oe", 32'(s), 32'(serr_oe));
      chk("serr wire", 32'(s == 0), 32'(serr_w));
      @(posedge sys_clk_in);
      ecmd <= '0;
      rchk("serr flag", FIXED | cmd_e | (s ? 32'h4000_0000 : 0));
      apb(1'b1, OFF, 32'h4000_0000 | cmd_e);
    end
    // pin flag follows bit 6; bit 31 left out of this compare
    for (int s = 0; s < 2; s++)
    begin
      cmd_e = s ? 16'h0040 : 16'h0000;
      apb(1'b1, OFF, {16'h0, cmd_e});
      @(posedge sys_clk_in);
      perr_cmd <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      #1 chk("pin action", 32'(s), 32'(trsp.parity_action));
      @(posedge sys_clk_in);
      perr_cmd <= 1'b0;
      repeat (5) @(posedge sys_clk_in);
      apb(1'b0, OFF, 32'h0);
      chk("pin flag", FIXED | cmd_e | (s ? 32'h0100_0000 : 0),
        rd & 32'h7fff_ffff);
      apb(1'b1, OFF, 32'h8100_0000 | cmd_e);
    end
    // random decode traffic, palette hits forced on odd steps
    for (int k = 0; k < 96; k++)
    begin
      if (k % 8 == 0)
      begin
        w16 = 16'($urandom);
        apb(1'b1, OFF, {16'h0, w16});
        cmd_e = w16 & CMD_WRITE_MASK;
      end
      t = txn_req_t'(21'($urandom));
      if (k % 2 == 1)
        t.addr[9:0] = pals[k % 3];
      e = '0;
      e.parity_error_detected = 1'($urandom);
      @(posedge sys_clk_in);
      tcmd <= t;
      ecmd <= e;
      @(posedge sys_clk_in);
      #1 chk("decode", 32'(exp_rsp(cmd_e, t, e)),
        32'(trsp));
    end
    conclude();
  end
endmodule
